/* File: pkg/sisp_pkg.sv */
package sisp_pkg;

    // Number of safety input terminals
    localparam int unsigned NUM_TERMINALS = 4;

    // Byte indices of the two status ports in the I/O map
    localparam logic [0:0] LEVEL_HEALTH_INDEX = 1'h0;
    localparam logic [0:0] TERMINAL_DIAG_INDEX = 1'h1;

    // Bit positions in the level and health byte
    localparam int unsigned LEVEL_POS = 0;
    localparam int unsigned CONN_ACTIVE_POS = 4;
    localparam int unsigned ALL_TERMINALS_OK_POS = 5;
    localparam int unsigned UNIT_OK_POS = 6;
    localparam int unsigned SUPPLY_FAULT_POS = 7;

    // Bit position of terminal 0 in the diagnostic byte
    localparam int unsigned DIAG_POS = 0;

    // Reset values
    localparam logic [7:0] LEVEL_HEALTH_RESET = 8'h00;
    localparam logic [7:0] TERMINAL_DIAG_RESET = 8'h00;
    localparam logic       FLAG_RESET = 1'h0;

endpackage

/* File: src/sisp_channel.sv */
`timescale 1ns/1ps

module sisp_channel (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic level_in,
    input  wire logic diag_ok_in,
    output logic      level,
    output logic      diag_ok
);

    // Logical level of the terminal, 1 for on
    always_ff @(posedge clk) begin
        if (!resetn) begin
            level <= sisp_pkg::FLAG_RESET;
        end else begin
            level <= level_in;
        end
    end

    // Diagnostic state of the terminal, 1 for no error
    always_ff @(posedge clk) begin
        if (!resetn) begin
            diag_ok <= sisp_pkg::FLAG_RESET;
        end else begin
            diag_ok <= diag_ok_in;
        end
    end

endmodule

/* File: src/sisp_status_ports.sv */
`timescale 1ns/1ps

// Contract
// - Four read-only terminal level bits, 1 on, 0 off, reset to 0.
// - Connection-active flag is 1 while safety connection stands, else 0.
// - Per-terminal diagnostic bits, 1 no error; aggregate 1 only if all ok.
// - Unit-health flag 1 when unit error-free, 0 on any error, reset 0.
// - Supply fault flag 1 when I/O supply bad or absent, else 0.
module sisp_status_ports (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [3:0] terminal_level_in,
    input  wire logic [3:0] terminal_diag_ok_in,
    input  wire logic       conn_established_in,
    input  wire logic       unit_error_in,
    input  wire logic       supply_fault_in,
    input  wire logic       rd_en,
    input  wire logic [0:0] rd_index,
    output logic            rd_valid,
    output logic [7:0]      rd_data,
    output logic [7:0]      input_level_and_health_byte,
    output logic [7:0]      terminal_diagnostic_byte
);

    logic [3:0] terminal_level;
    logic [3:0] terminal_diag_ok;
    logic       conn_active;
    logic       unit_ok;
    logic       supply_fault;
    logic       all_terminals_ok;

    // One channel per terminal
    genvar gi;
    generate
        for (gi = 0; gi < sisp_pkg::NUM_TERMINALS; gi = gi + 1) begin : g_chan
            sisp_channel u_chan (
                .clk        (clk),
                .resetn     (resetn),
                .level_in   (terminal_level_in[gi]),
                .diag_ok_in (terminal_diag_ok_in[gi]),
                .level      (terminal_level[gi]),
                .diag_ok    (terminal_diag_ok[gi])
            );
        end
    endgenerate

    // Connection activity
    always_ff @(posedge clk) begin
        if (!resetn) begin
            conn_active <= sisp_pkg::FLAG_RESET;
        end else begin
            conn_active <= conn_established_in;
        end
    end

    // Unit health
    always_ff @(posedge clk) begin
        if (!resetn) begin
            unit_ok <= sisp_pkg::FLAG_RESET;
        end else begin
            unit_ok <= !unit_error_in;
        end
    end

    // Input supply fault
    always_ff @(posedge clk) begin
        if (!resetn) begin
            supply_fault <= sisp_pkg::FLAG_RESET;
        end else begin
            supply_fault <= supply_fault_in;
        end
    end

    // Aggregate follows the registered diagnostic bits, so it stays 0 in reset
    assign all_terminals_ok = &terminal_diag_ok;

    // Byte packing
    always_comb begin
        input_level_and_health_byte = sisp_pkg::LEVEL_HEALTH_RESET;
        input_level_and_health_byte[sisp_pkg::LEVEL_POS +: 4] = terminal_level;
        input_level_and_health_byte[sisp_pkg::CONN_ACTIVE_POS] = conn_active;
        input_level_and_health_byte[sisp_pkg::ALL_TERMINALS_OK_POS] = all_terminals_ok;
        input_level_and_health_byte[sisp_pkg::UNIT_OK_POS] = unit_ok;
        input_level_and_health_byte[sisp_pkg::SUPPLY_FAULT_POS] = supply_fault;
        terminal_diagnostic_byte = sisp_pkg::TERMINAL_DIAG_RESET;
        terminal_diagnostic_byte[sisp_pkg::DIAG_POS +: 4] = terminal_diag_ok;
    end

    // Read answer one cycle after the request
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_valid <= 1'h0;
        end else begin
            rd_valid <= rd_en;
        end
    end

    // Read data holds until the next read
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            case (rd_index)
                sisp_pkg::LEVEL_HEALTH_INDEX: begin
                    rd_data <= input_level_and_health_byte;
                end
                sisp_pkg::TERMINAL_DIAG_INDEX: begin
                    rd_data <= terminal_diagnostic_byte;
                end
                default: begin
                    rd_data <= 8'h00;
                end
            endcase
        end
    end

endmodule

/* File: verification/sisp_monitor.sv */
`timescale 1ns/1ps
module sisp_monitor (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [3:0] terminal_level_in,
    input wire logic [3:0] terminal_diag_ok_in,
    input wire logic       conn_established_in,
    input wire logic       unit_error_in,
    input wire logic       supply_fault_in,
    input wire logic [7:0] input_level_and_health_byte,
    input wire logic [7:0] terminal_diagnostic_byte,
    input wire logic       rd_en,
    input wire logic       rd_valid
);
    wire [7:0] lh = input_level_and_health_byte;
    wire [7:0] dg = terminal_diagnostic_byte;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_level_follow:
    assert property ($past(resetn) |-> lh[3:0] == $past(terminal_level_in)) else $error("level bits");
    a_conn_follow:
    assert property ($past(resetn) |-> lh[4] == $past(conn_established_in)) else $error("conn flag");
    a_diag_all_ok:
    assert property ($past(resetn) |-> dg == {4'h0, $past(terminal_diag_ok_in)} && lh[5] == &dg[3:0]) else $error("diag");
    a_unit_health:
    assert property ($past(resetn) |-> lh[6] != $past(unit_error_in)) else $error("unit flag");
    a_supply_fault:
    assert property ($past(resetn) |-> lh[7] == $past(supply_fault_in)) else $error("supply flag");
    a_reset_clear:
    assert property (disable iff (1'b0) !resetn |=> lh == 8'h00 && dg == 8'h00) else $error("reset value");
    a_read_answer:
    assert property ($past(resetn) |-> rd_valid == $past(rd_en)) else $error("read valid");
endmodule

bind sisp_status_ports sisp_monitor u_monitor (.*);

/* File: verification/sisp_reader.sv */
`timescale 1ns/1ps
module sisp_reader (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [0:0] idx,
    output logic            rd_en,
    output logic [0:0]      rd_index
);
    // Controller polls one byte a cycle
    always_ff @(posedge clk) begin
        rd_en    <= go;
        rd_index <= idx;
    end
endmodule

/* File: verification/sisp_status_ports_bench.sv */
`timescale 1ns/1ps
module sisp_status_ports_bench;
    logic        clk, resetn, conn_established_in, unit_error_in, supply_fault_in, rd_en, rd_valid, go, smp, sen;
    logic [3:0]  terminal_level_in, terminal_diag_ok_in;
    logic [0:0]  rd_index, idx, six;
    logic [7:0]  rd_data, input_level_and_health_byte, terminal_diagnostic_byte, plh, pdg, erd, elh, edg;
    logic [10:0] sv;
    logic [12:0] r;
    int          err_count, total_checks, i, seed;
    sisp_status_ports DUT (.*);
    sisp_reader u_reader (.clk(clk), .go(go), .idx(idx), .rd_en(rd_en), .rd_index(rd_index));
    function automatic logic [7:0] f_lh(input logic [10:0] s);
        return {s[0], !s[1], &s[6:3], s[2], s[10:7]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        smp <= resetn;
        sen <= rd_en;
        six <= rd_index;
        sv  <= {terminal_level_in, terminal_diag_ok_in, conn_established_in, unit_error_in, supply_fault_in};
    end
    always @(negedge clk) begin
        elh = smp ? f_lh(sv) : 8'h00;
        edg = smp ? {4'h0, sv[6:3]} : 8'h00;
        erd = !smp ? 8'h00 : sen ? (six ? pdg : plh) : erd;
        check(input_level_and_health_byte, elh);
        check(terminal_diagnostic_byte, edg);
        check({7'h00, rd_valid}, {7'h00, smp & sen});
        check(rd_data, erd);
        plh = elh;
        pdg = edg;
    end
    initial begin
        seed = 32'hf2f1;
        {resetn, go, idx} = 3'h0;
        {terminal_level_in, terminal_diag_ok_in, conn_established_in, unit_error_in, supply_fault_in} = 11'h000;
        repeat (19) @(posedge clk);
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            r = 13'($random(seed));
            if (i % 9 == 0) r[6:3] = 4'hF;
            resetn <= !(i > 200 && i < 204);
            {go, idx, terminal_level_in, terminal_diag_ok_in, conn_established_in, unit_error_in, supply_fault_in} <= r;
        end
        $display("random status and read test done");
        conclude();
    end
endmodule
